// [hdl/cpdx_defs.svh]
// Offsets, field positions, reset values and frame byte counts of the cyclic exchange
`ifndef CPDX_DEFS_SVH
`define CPDX_DEFS_SVH

`define CPDX_CMD_BYTES      4'd8
`define CPDX_RPL_BYTES      3'd5
`define CPDX_IDX_CTRL0      3'd0
`define CPDX_IDX_CTRL1      3'd1
`define CPDX_IDX_SPARE      3'd2
`define CPDX_IDX_PARAM_ID   3'd3
`define CPDX_IDX_VAL0       3'd4
`define CPDX_C0_RESET       6
`define CPDX_C0_ENABLE      5
`define CPDX_C0_REVERSE     4
`define CPDX_CONF_CLR_ACK   7
`define CPDX_CONF_ENABLED   6
`define CPDX_CONF_REVERSE   5
`define CPDX_CONF_IN_POS    4
`define CPDX_CONF_WAIT      3
`define CPDX_CMD_MASK       8'h7f
`define CPDX_ERR_MASK       8'h7f
`define CPDX_STATE_IDLE     3'h6
`define CPDX_STATE_DURING   3'h3
`define CPDX_RST_BYTE       8'h00

`endif

// [hdl/cpdx_pkg.sv]
// Types of the cyclic process-data exchange block
package cpdx_pkg;
    typedef logic [7:0] cpdx_byte_t;
    typedef enum logic [1:0] {
        CPDX_IDLE  = 2'b00,
        CPDX_RECV  = 2'b01,
        CPDX_DONE  = 2'b11
    } cpdx_rx_e;
endpackage : cpdx_pkg

// [hdl/cpdx_reply.sv]
// Reply frame builder: serialises the five reply bytes
`timescale 1ns/1ps
`include "cpdx_defs.svh"
module cpdx_reply (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              start,
    input  wire cpdx_pkg::cpdx_byte_t frame [5],
    output logic                   tx_valid,
    output cpdx_pkg::cpdx_byte_t   tx_data,
    output logic                   tx_last
);
    import cpdx_pkg::*;
    logic [2:0] idx_r;
    logic [2:0] idx_nxt;
    logic       act_r;
    logic       act_nxt;
    cpdx_byte_t dat_r;
    cpdx_byte_t dat_nxt;
    logic       last_r;
    logic       last_nxt;

    always_comb begin
        idx_nxt  = idx_r;
        act_nxt  = act_r;
        dat_nxt  = dat_r;
        last_nxt = 1'b0;
        if (act_r) begin
            if (idx_r == `CPDX_RPL_BYTES - 3'd1) begin
                act_nxt = 1'b0;
            end else begin
                idx_nxt  = idx_r + 3'd1;
                dat_nxt  = frame[idx_r + 3'd1];
                last_nxt = (idx_r + 3'd1 == `CPDX_RPL_BYTES - 3'd1);
            end
        end else if (start) begin
            act_nxt = 1'b1;
            idx_nxt = 3'd0;
            dat_nxt = frame[0];
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            idx_r  <= 3'd0;
            act_r  <= 1'b0;
            dat_r  <= `CPDX_RST_BYTE;
            last_r <= 1'b0;
        end else begin
            idx_r  <= idx_nxt;
            act_r  <= act_nxt;
            dat_r  <= dat_nxt;
            last_r <= last_nxt;
        end
    end

    assign tx_valid = act_r;
    assign tx_data  = act_r ? dat_r : `CPDX_RST_BYTE;
    assign tx_last  = act_r & last_r;
endmodule : cpdx_reply

// [hdl/cpdx_core.sv]
// Cyclic process-data command interpreter, motor side
//
// Contract
// - Command frame is eight bytes: two control, spare, param ID, value low first.
// - Any table parameter is accepted by its instance number, any protocol.
// - Control byte 0: reset alarm, enable, reverse, outputs 4..1; bit 7 ignored.
// - Control byte 1: wait angles, receive from 3..1, release to 2..1.
// - Reply byte 0 shows digital inputs 8..1 on bits 7..0.
// - Confirmation byte 1: clear ack, enabled, reverse, in position, wait, state.
// - Three-bit state code per unit kind, function or drive.
// - Confirmation byte 2 echoes completion in control byte 1 positions.
// - Error byte flags seven faults on bits 6..0; bit 7 zero.
// - Cyclic data stays eight bytes or less; acyclic only on request.
// - Stand-alone mode ignores the network, runs on digital inputs.
`timescale 1ns/1ps
`include "cpdx_defs.svh"
module cpdx_core (
    input  wire logic                 clock,
    input  wire logic                 resetn,
    input  wire logic                 rx_valid,
    input  wire cpdx_pkg::cpdx_byte_t rx_data,
    input  wire logic                 rx_first,
    input  wire logic                 stand_alone,
    input  wire logic [7:0]           digital_input,
    input  wire logic                 in_position,
    input  wire logic                 state_wait,
    input  wire logic [2:0]           state_code,
    input  wire logic [6:0]           cmd_done,
    input  wire logic [6:0]           fault_flags,
    input  wire logic                 clear_ack,
    output logic                      alarm_reset,
    output logic                      drive_enable,
    output logic                      speed_reverse,
    output logic [3:0]                digital_output,
    output logic [6:0]                motion_cmd,
    output logic                      param_valid,
    output cpdx_pkg::cpdx_byte_t      param_id,
    output logic [31:0]               param_value,
    output logic                      cmd_ready,
    output logic                      tx_valid,
    output cpdx_pkg::cpdx_byte_t      tx_data,
    output logic                      tx_last
);
    import cpdx_pkg::*;

    // ---------------------------------------------
    // Frame reception
    // ---------------------------------------------
    cpdx_rx_e   st_r;
    cpdx_rx_e   st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    cpdx_byte_t buf_r [8];
    cpdx_byte_t buf_nxt [8];
    logic       done_pulse;

    function automatic logic frame_end(input logic [3:0] c);
        frame_end = (c == `CPDX_CMD_BYTES - 4'd1);
    endfunction : frame_end

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        buf_nxt = buf_r;
        done_pulse = 1'b0;
        case (st_r)
            CPDX_IDLE, CPDX_DONE: begin
                st_nxt = CPDX_IDLE;
                if (rx_valid && rx_first && !stand_alone) begin
                    buf_nxt[0] = rx_data;
                    cnt_nxt    = 4'd1;
                    st_nxt     = CPDX_RECV;
                end
            end
            CPDX_RECV: begin
                if (rx_valid && rx_first) begin
                    // Resync on a fresh frame start
                    buf_nxt[0] = rx_data;
                    cnt_nxt    = 4'd1;
                end else if (rx_valid) begin
                    buf_nxt[cnt_r[2:0]] = rx_data;
                    cnt_nxt = cnt_r + 4'd1;
                    if (frame_end(cnt_r)) begin
                        st_nxt     = CPDX_DONE;
                        done_pulse = 1'b1;
                    end
                end
                if (stand_alone) begin
                    st_nxt = CPDX_IDLE;
                    done_pulse = 1'b0;
                end
            end
            default: st_nxt = CPDX_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_r  <= CPDX_IDLE;
            cnt_r <= 4'd0;
            for (int i = 0; i < 8; i++) begin
                buf_r[i] <= `CPDX_RST_BYTE;
            end
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            buf_r <= buf_nxt;
        end
    end

    // ---------------------------------------------
    // Command decode
    // ---------------------------------------------
    cpdx_byte_t c0_r;
    cpdx_byte_t c0_nxt;
    logic [6:0] mc_r;
    logic [6:0] mc_nxt;
    cpdx_byte_t pid_r;
    cpdx_byte_t pid_nxt;
    logic [31:0] pv_r;
    logic [31:0] pv_nxt;
    logic       pvld_r;
    logic       pvld_nxt;

    always_comb begin
        c0_nxt   = c0_r;
        mc_nxt   = mc_r;
        pid_nxt  = pid_r;
        pv_nxt   = pv_r;
        pvld_nxt = 1'b0;
        if (stand_alone) begin
            // Network commands dropped; drive follows power
            c0_nxt = `CPDX_RST_BYTE;
            mc_nxt = 7'h00;
        end else if (st_r == CPDX_DONE) begin
            c0_nxt  = buf_r[`CPDX_IDX_CTRL0] & `CPDX_CMD_MASK;
            mc_nxt  = buf_r[`CPDX_IDX_CTRL1][6:0];
            pid_nxt = buf_r[`CPDX_IDX_PARAM_ID];
            pv_nxt  = {buf_r[7], buf_r[6], buf_r[5], buf_r[`CPDX_IDX_VAL0]};
            pvld_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            c0_r   <= `CPDX_RST_BYTE;
            mc_r   <= 7'h00;
            pid_r  <= `CPDX_RST_BYTE;
            pv_r   <= 32'h0000_0000;
            pvld_r <= 1'b0;
        end else begin
            c0_r   <= c0_nxt;
            mc_r   <= mc_nxt;
            pid_r  <= pid_nxt;
            pv_r   <= pv_nxt;
            pvld_r <= pvld_nxt;
        end
    end

    assign alarm_reset    = c0_r[`CPDX_C0_RESET];
    assign drive_enable   = stand_alone | c0_r[`CPDX_C0_ENABLE];
    assign speed_reverse  = c0_r[`CPDX_C0_REVERSE];
    assign digital_output = stand_alone ? 4'h0 : c0_r[3:0];
    assign motion_cmd     = mc_r;
    assign param_valid    = pvld_r;
    assign param_id       = pid_r;
    assign param_value    = pv_r;
    // Advisory only; the controller owns the pacing
    assign cmd_ready = ((state_code == `CPDX_STATE_IDLE) ||
                        (state_code == `CPDX_STATE_DURING)) && (mc_r[4:0] == 5'h00);

    // ---------------------------------------------
    // Reply frame
    // ---------------------------------------------
    cpdx_byte_t rpl [5];
    always_comb begin
        rpl[0] = digital_input;
        rpl[1] = {clear_ack, drive_enable, speed_reverse, in_position,
                  state_wait, state_code};
        rpl[2] = {1'b0, cmd_done};
        rpl[3] = {1'b0, fault_flags};
        rpl[4] = `CPDX_RST_BYTE;
    end

    cpdx_reply u_reply (
        .clock    (clock),
        .resetn   (resetn),
        .start    (done_pulse),
        .frame    (rpl),
        .tx_valid (tx_valid),
        .tx_data  (tx_data),
        .tx_last  (tx_last)
    );

    // ---------------------------------------------
    // Assertions
    // ---------------------------------------------
    property p_frame_decode;
        @(posedge clock) disable iff (!resetn)
        (st_r == CPDX_DONE && !stand_alone) |=>
            (motion_cmd == $past(buf_r[1][6:0])) && param_valid;
    endproperty
    a_frame_decode: assert property (p_frame_decode) else $error("ctrl1 decode wrong");
    property p_value_order;
        @(posedge clock) disable iff (!resetn)
        param_valid |-> param_value[7:0] == $past(buf_r[4]);
    endproperty
    a_value_order: assert property (p_value_order) else $error("value byte order wrong");
    property p_ctrl0_b7;
        @(posedge clock) disable iff (!resetn)
        (st_r == CPDX_DONE && !stand_alone) |=>
            !c0_r[7] && (c0_r[6:0] == $past(buf_r[0][6:0]));
    endproperty
    a_ctrl0_b7: assert property (p_ctrl0_b7) else $error("ctrl0 bit7 kept");
    property p_stand_alone;
        @(posedge clock) disable iff (!resetn)
        stand_alone[*2] |-> drive_enable && motion_cmd == 7'h00 && !param_valid;
    endproperty
    a_stand_alone: assert property (p_stand_alone) else $error("network obeyed standalone");
    property p_reply_start;
        @(posedge clock) disable iff (!resetn)
        done_pulse |=> tx_valid && tx_data == $past(digital_input);
    endproperty
    a_reply_start: assert property (p_reply_start) else $error("reply byte0 wrong");
    property p_reply_len;
        @(posedge clock) disable iff (!resetn)
        $rose(tx_valid) |-> tx_valid[*5] ##1 !tx_valid;
    endproperty
    a_reply_len: assert property (p_reply_len) else $error("reply not 5 bytes");
    property p_spare_zero;
        @(posedge clock) disable iff (!resetn) tx_last |-> tx_data == 8'h00;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare not zero");
    property p_err_b7;
        @(posedge clock) disable iff (!resetn)
        done_pulse |-> ##4 (tx_data[7] == 1'b0 && tx_data[6:0] == $past(fault_flags));
    endproperty
    a_err_b7: assert property (p_err_b7) else $error("error byte wrong");
    c_frame: cover property (@(posedge clock) done_pulse);
    c_both: cover property (@(posedge clock) motion_cmd[4:2] != 3'h0 && motion_cmd[1:0] != 2'h0);
    c_sa: cover property (@(posedge clock) stand_alone && rx_valid);
endmodule : cpdx_core

// [testbench/cpdx_ctrl_model.sv]
// Line controller model: sends command frames and collects reply frames
`timescale 1ns/1ps
module cpdx_ctrl_model (
    input  wire logic                 clock,
    output logic                      rx_valid,
    output cpdx_pkg::cpdx_byte_t      rx_data,
    output logic                      rx_first,
    input  wire logic                 tx_valid,
    input  wire cpdx_pkg::cpdx_byte_t tx_data,
    input  wire logic                 tx_last
);
    import cpdx_pkg::*;
    cpdx_byte_t rpl [5];
    int         rpl_cnt;
    int         last_at;

    initial begin
        rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_data  = 8'h00;
        rpl_cnt  = 0;
        last_at  = -1;
    end

    // ----------------------------------------
    // Reply capture, one byte per valid cycle
    // ----------------------------------------
    always @(posedge clock) begin
        if (tx_valid === 1'b1) begin
            if (rpl_cnt < 5) rpl[rpl_cnt] <= tx_data;
            if (tx_last === 1'b1) last_at <= rpl_cnt;
            rpl_cnt <= rpl_cnt + 1;
        end
    end

    task automatic clear_rpl();
        rpl_cnt = 0;
        last_at = -1;
    endtask : clear_rpl

    // Eight bytes, byte 0 first, value low byte first
    task automatic send_frame(input logic [63:0] f, input logic first_on);
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            rx_valid <= 1'b1;
            rx_first <= first_on && (i == 0);
            rx_data  <= f[8*i +: 8];
        end
        @(posedge clock);
        rx_valid <= 1'b0;
        rx_first <= 1'b0;
        rx_data  <= ~f[63:56];  // Idle line never repeats the last byte
    endtask : send_frame
endmodule : cpdx_ctrl_model

// [testbench/tb_cyclic_process_data_exchange.sv]
// Self-checking testbench of the motor-side cyclic exchange interpreter
`timescale 1ns/1ps
module tb_cyclic_process_data_exchange;
    import cpdx_pkg::*;
    logic        clock, resetn, rx_valid, rx_first, stand_alone;
    logic        in_position, state_wait, clear_ack;
    logic        alarm_reset, drive_enable, speed_reverse, param_valid, cmd_ready;
    logic        tx_valid, tx_last;
    cpdx_byte_t  rx_data, param_id, tx_data;
    logic [7:0]  digital_input;
    logic [2:0]  state_code;
    logic [6:0]  cmd_done, fault_flags, motion_cmd;
    logic [3:0]  digital_output;
    logic [31:0] param_value;
    int          errors, num_checks, pv_cnt;

    cpdx_core dut_u (.clock(clock), .resetn(resetn), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_first(rx_first), .stand_alone(stand_alone),
        .digital_input(digital_input), .in_position(in_position),
        .state_wait(state_wait), .state_code(state_code), .cmd_done(cmd_done),
        .fault_flags(fault_flags), .clear_ack(clear_ack), .alarm_reset(alarm_reset),
        .drive_enable(drive_enable), .speed_reverse(speed_reverse),
        .digital_output(digital_output), .motion_cmd(motion_cmd),
        .param_valid(param_valid), .param_id(param_id), .param_value(param_value),
        .cmd_ready(cmd_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));

    cpdx_ctrl_model model_u (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_first(rx_first), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        if (param_valid === 1'b1) pv_cnt <= pv_cnt + 1;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    // Reply window is fixed at seven cycles after the last byte
    task automatic frame(input logic [63:0] f, input logic first_on);
        model_u.clear_rpl();
        model_u.send_frame(f, first_on);
        repeat (7) @(posedge clock);
    endtask : frame

    task automatic chk_rpl(input logic [39:0] e);
        chk(model_u.rpl_cnt, 5);
        chk(model_u.last_at, 4);
        for (int i = 0; i < 5; i++) chk(model_u.rpl[i], e[8*i +: 8]);
    endtask : chk_rpl

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        resetn = 1'b0;
        stand_alone = 1'b0;
        digital_input = 8'h96;
        in_position = 1'b1;
        state_wait = 1'b0;
        clear_ack = 1'b1;
        state_code = 3'h6;
        cmd_done = 7'h55;
        fault_flags = 7'h2a;
        errors = 0;
        num_checks = 0;
        pv_cnt = 0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        chk({alarm_reset, drive_enable, speed_reverse, digital_output, motion_cmd}, 0);
        chk({tx_valid, param_valid}, 0);
        // All commands, receive and release together, bit 7s set
        frame(64'h44332211_2fa5ffff, 1'b1);
        frame(64'h44332211_2fa5ffff, 1'b1);
        chk(pv_cnt, 2);
        chk({alarm_reset, drive_enable, speed_reverse}, 3'h7);
        chk(digital_output, 4'hf);
        chk(motion_cmd, 7'h7f);
        chk(param_id, 8'h2f);
        chk(param_value, 32'h44332211);
        chk(cmd_ready, 1'b0);
        chk_rpl(40'h00_2a_55_f6_96);
        // Commands cleared after confirmation, different reply fields
        digital_input <= 8'h69;
        in_position <= 1'b0;
        state_wait <= 1'b1;
        clear_ack <= 1'b0;
        state_code <= 3'h3;
        cmd_done <= 7'h2a;
        fault_flags <= 7'h55;
        frame(64'ha1b2c3d4_305a6080, 1'b1);
        frame(64'ha1b2c3d4_305a6080, 1'b1);
        chk(pv_cnt, 4);
        chk({alarm_reset, drive_enable, speed_reverse, digital_output}, 0);
        chk(motion_cmd, 7'h60);
        chk(param_value, 32'ha1b2c3d4);
        chk(param_id, 8'h30);
        chk(cmd_ready, 1'b1);
        chk_rpl(40'h00_55_2a_0b_69);
        @(posedge clock);
        state_code <= 3'h5;
        repeat (2) @(posedge clock);
        chk(cmd_ready, 1'b0);
        // Bytes without a frame start are ignored
        frame(64'h44332211_2fa5ffff, 1'b0);
        chk(pv_cnt, 4);
        chk(model_u.rpl_cnt, 0);
        chk(motion_cmd, 7'h60);
        // Stand-alone ignores the network
        stand_alone <= 1'b1;
        frame(64'h44332211_2fa5ffff, 1'b1);
        chk({drive_enable, digital_output}, 5'h10);
        chk(pv_cnt, 4);
        chk(model_u.rpl_cnt, 0);
        chk(motion_cmd, 7'h00);
        close_out();
    end
endmodule : tb_cyclic_process_data_exchange
